// >>> include/tpio_pkg.sv
// Shared constants for the three-port parallel I/O block
package tpio_pkg;

  // Port widths
  localparam int TPIO_A_WIDTH = 8;
  localparam int TPIO_B_WIDTH = 8;
  localparam int TPIO_C_WIDTH = 4;
  localparam int TPIO_REG_WIDTH = 8;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] TPIO_IDX_DATA_A = 8'h00;
  localparam logic [7:0] TPIO_IDX_DATA_B = 8'h01;
  localparam logic [7:0] TPIO_IDX_DATA_C = 8'h02;
  localparam logic [7:0] TPIO_IDX_DIR_A  = 8'h04;
  localparam logic [7:0] TPIO_IDX_DIR_B  = 8'h05;
  localparam logic [7:0] TPIO_IDX_DIR_C  = 8'h06;

  // Address decode
  localparam int TPIO_ADDR_WIDTH = 32;
  localparam int TPIO_IDX_LSB    = 2;
  localparam int TPIO_IDX_WIDTH  = 8;

  // Read value of unused data bits of the narrow port
  localparam logic [7:0] TPIO_C_UNUSED_ONES = 8'hf0;

  // Reset values
  localparam logic [7:0]  TPIO_DIR_RESET  = 8'h00;
  localparam logic [31:0] TPIO_WORD_ZERO  = 32'h0000_0000;

  // AHB-Lite encodings
  localparam logic [1:0] TPIO_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] TPIO_HSIZE_WORD    = 3'h2;
  localparam logic       TPIO_HRESP_OKAY    = 1'h0;

  // Output styles, chosen per whole port at build time
  typedef enum logic [1:0] {
    TPIO_STYLE_STANDARD,
    TPIO_STYLE_PULLUP,
    TPIO_STYLE_OPEN_DRAIN
  } tpio_style_type;

endpackage : tpio_pkg

// >>> logic/tpio_sync.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module tpio_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  // Asynchronous pin levels
  input  wire logic [WIDTH-1:0] i_async,
  // Levels on the system clock
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } tpio_sync_state_type;

  tpio_sync_state_type state_reg;
  tpio_sync_state_type state_next;

  initial begin
    if (WIDTH < 1) begin
      $error("tpio_sync: WIDTH must be at least one");
    end
  end

  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = i_async;
    // First stage feeds only the second
    state_next.stage2 = state_reg.stage1;
    if (!i_reset_n) begin
      state_next.stage1 = '0;
      state_next.stage2 = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    state_reg <= state_next;
  end

  assign o_sync = state_reg.stage2;

endmodule : tpio_sync

// >>> logic/tpio_top.sv
// Three-port parallel I/O block with an AHB-Lite register slave
`timescale 1ns/1ps
module tpio_top
  import tpio_pkg::*;
#(
  parameter int             A_WIDTH = TPIO_A_WIDTH,
  parameter int             B_WIDTH = TPIO_B_WIDTH,
  parameter int             C_WIDTH = TPIO_C_WIDTH,
  parameter tpio_style_type A_STYLE = TPIO_STYLE_STANDARD,
  parameter tpio_style_type B_STYLE = TPIO_STYLE_STANDARD,
  parameter tpio_style_type C_STYLE = TPIO_STYLE_STANDARD
) (
  // Clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_reset_n,
  // AHB-Lite slave
  input  wire logic                       i_hsel,
  input  wire logic [TPIO_ADDR_WIDTH-1:0] i_haddr,
  input  wire logic [1:0]                 i_htrans,
  input  wire logic                       i_hwrite,
  input  wire logic [2:0]                 i_hsize,
  input  wire logic [31:0]                i_hwdata,
  input  wire logic                       i_hready,
  output logic                            o_hreadyout,
  output logic                            o_hresp,
  output logic      [31:0]                o_hrdata,
  // First port pins
  input  wire logic [A_WIDTH-1:0]         i_first_port_lines_in,
  output logic      [A_WIDTH-1:0]         o_first_port_lines_out,
  output logic      [A_WIDTH-1:0]         o_first_port_lines_oe,
  // Second port pins
  input  wire logic [B_WIDTH-1:0]         i_second_port_lines_in,
  output logic      [B_WIDTH-1:0]         o_second_port_lines_out,
  output logic      [B_WIDTH-1:0]         o_second_port_lines_oe,
  // Narrow port pins
  input  wire logic [C_WIDTH-1:0]         i_narrow_port_lines_in,
  output logic      [C_WIDTH-1:0]         o_narrow_port_lines_out,
  output logic      [C_WIDTH-1:0]         o_narrow_port_lines_oe
);

  // Whole block state; the data latches carry no reset value
  typedef struct packed {
    logic [A_WIDTH-1:0]        latch_a;
    logic [B_WIDTH-1:0]        latch_b;
    logic [C_WIDTH-1:0]        latch_c;
    logic [A_WIDTH-1:0]        dir_a;
    logic [B_WIDTH-1:0]        dir_b;
    logic [C_WIDTH-1:0]        dir_c;
    logic                      wr_pend;
    logic [TPIO_IDX_WIDTH-1:0] wr_idx;
    logic                      hreadyout;
    logic                      hresp;
    logic [31:0]               hrdata;
    logic [A_WIDTH-1:0]        out_a;
    logic [A_WIDTH-1:0]        oe_a;
    logic [B_WIDTH-1:0]        out_b;
    logic [B_WIDTH-1:0]        oe_b;
    logic [C_WIDTH-1:0]        out_c;
    logic [C_WIDTH-1:0]        oe_c;
  } tpio_state_type;

  tpio_state_type state_reg;
  tpio_state_type state_next;

  // Synchronised pin levels
  logic [A_WIDTH-1:0] pin_a;
  logic [B_WIDTH-1:0] pin_b;
  logic [C_WIDTH-1:0] pin_c;

  initial begin
    if (A_WIDTH < 1 || A_WIDTH > TPIO_REG_WIDTH) begin
      $error("tpio_top: first port width must lie between one and eight");
    end
    if (B_WIDTH < 1 || B_WIDTH > TPIO_REG_WIDTH) begin
      $error("tpio_top: second port width must lie between one and eight");
    end
    // The read-as-ones mask of the narrow port assumes four stored lines
    if (C_WIDTH != TPIO_C_WIDTH) begin
      $error("tpio_top: narrow port width must stay four");
    end
    if (TPIO_IDX_LSB + TPIO_IDX_WIDTH > TPIO_ADDR_WIDTH) begin
      $error("tpio_top: register index field lies outside the address");
    end
    if (A_STYLE > TPIO_STYLE_OPEN_DRAIN || B_STYLE > TPIO_STYLE_OPEN_DRAIN ||
        C_STYLE > TPIO_STYLE_OPEN_DRAIN) begin
      $error("tpio_top: unknown output style");
    end
  end

  // Register selected by a word index; one decode serves writes and reads
  typedef enum logic [2:0] {
    TPIO_SEL_NONE,
    TPIO_SEL_DATA_A,
    TPIO_SEL_DATA_B,
    TPIO_SEL_DATA_C,
    TPIO_SEL_DIR_A,
    TPIO_SEL_DIR_B,
    TPIO_SEL_DIR_C
  } tpio_sel_type;

  function automatic tpio_sel_type reg_select(input logic [TPIO_IDX_WIDTH-1:0] idx);
    unique case (idx)
      TPIO_IDX_DATA_A: reg_select = TPIO_SEL_DATA_A;
      TPIO_IDX_DATA_B: reg_select = TPIO_SEL_DATA_B;
      TPIO_IDX_DATA_C: reg_select = TPIO_SEL_DATA_C;
      TPIO_IDX_DIR_A:  reg_select = TPIO_SEL_DIR_A;
      TPIO_IDX_DIR_B:  reg_select = TPIO_SEL_DIR_B;
      TPIO_IDX_DIR_C:  reg_select = TPIO_SEL_DIR_C;
      default:         reg_select = TPIO_SEL_NONE;
    endcase
  endfunction : reg_select

  // Read source per bit: pin for inputs, latch for outputs
  function automatic logic [7:0] read_mix(input logic [7:0] dir,
                                          input logic [7:0] latch,
                                          input logic [7:0] pin);
    read_mix = (dir & latch) | (~dir & pin);
  endfunction : read_mix

  // Pin value per output style; open drain only pulls low
  function automatic logic [7:0] drive_out(input tpio_style_type style,
                                           input logic [7:0] dir,
                                           input logic [7:0] latch);
    if (style == TPIO_STYLE_OPEN_DRAIN) begin
      drive_out = 8'h00;
    end else begin
      drive_out = dir & latch;
    end
  endfunction : drive_out

  // Pin enable per output style; open drain enables only its low bits
  function automatic logic [7:0] drive_oe(input tpio_style_type style,
                                          input logic [7:0] dir,
                                          input logic [7:0] latch);
    if (style == TPIO_STYLE_OPEN_DRAIN) begin
      drive_oe = dir & ~latch;
    end else begin
      drive_oe = dir;
    end
  endfunction : drive_oe

  // Pin levels are synchronised before any read
  tpio_sync #(.WIDTH(A_WIDTH)) u_sync_a (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   (i_first_port_lines_in),
    .o_sync    (pin_a)
  );

  tpio_sync #(.WIDTH(B_WIDTH)) u_sync_b (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   (i_second_port_lines_in),
    .o_sync    (pin_b)
  );

  tpio_sync #(.WIDTH(C_WIDTH)) u_sync_c (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   (i_narrow_port_lines_in),
    .o_sync    (pin_c)
  );

  always_comb begin
    logic                      addr_valid;
    logic [TPIO_IDX_WIDTH-1:0] addr_idx;
    tpio_sel_type              wr_sel;
    tpio_sel_type              rd_sel;
    logic [7:0]                wbyte;
    logic [7:0]                rbyte;
    logic [7:0]                la;
    logic [7:0]                lb;
    logic [7:0]                lc;
    logic [7:0]                da;
    logic [7:0]                db;
    logic [7:0]                dc;
    logic [7:0]                pa;
    logic [7:0]                pb;
    logic [7:0]                pc;
    addr_valid = 1'b0;
    addr_idx   = '0;
    wr_sel     = TPIO_SEL_NONE;
    rd_sel     = TPIO_SEL_NONE;
    wbyte      = '0;
    rbyte      = '0;
    la         = '0;
    lb         = '0;
    lc         = '0;
    da         = '0;
    db         = '0;
    dc         = '0;
    pa         = '0;
    pb         = '0;
    pc         = '0;
    state_next = state_reg;

    // Data phase of a write taken last cycle
    wbyte  = i_hwdata[TPIO_REG_WIDTH-1:0];
    wr_sel = reg_select(state_reg.wr_idx);
    if (state_reg.wr_pend) begin
      unique case (wr_sel)
        TPIO_SEL_DATA_A: state_next.latch_a = wbyte[A_WIDTH-1:0];
        TPIO_SEL_DATA_B: state_next.latch_b = wbyte[B_WIDTH-1:0];
        TPIO_SEL_DATA_C: state_next.latch_c = wbyte[C_WIDTH-1:0];
        TPIO_SEL_DIR_A:  state_next.dir_a   = wbyte[A_WIDTH-1:0];
        TPIO_SEL_DIR_B:  state_next.dir_b   = wbyte[B_WIDTH-1:0];
        TPIO_SEL_DIR_C:  state_next.dir_c   = wbyte[C_WIDTH-1:0];
        TPIO_SEL_NONE:   ;
      endcase
    end

    // Address phase; reads see a write completing in the same cycle
    addr_valid = i_hsel && i_hready && (i_htrans == TPIO_HTRANS_NONSEQ);
    addr_idx   = i_haddr[TPIO_IDX_LSB +: TPIO_IDX_WIDTH];
    state_next.wr_pend = addr_valid && i_hwrite;
    state_next.wr_idx  = addr_idx;

    la = 8'(state_next.latch_a);
    lb = 8'(state_next.latch_b);
    lc = 8'(state_next.latch_c);
    da = 8'(state_next.dir_a);
    db = 8'(state_next.dir_b);
    dc = 8'(state_next.dir_c);
    pa = 8'(pin_a);
    pb = 8'(pin_b);
    pc = 8'(pin_c);

    // Read data of the address phase taken at this edge
    rd_sel = reg_select(addr_idx);
    unique case (rd_sel)
      TPIO_SEL_DATA_A: rbyte = read_mix(da, la, pa);
      TPIO_SEL_DATA_B: rbyte = read_mix(db, lb, pb);
      TPIO_SEL_DATA_C: rbyte = read_mix(dc, lc, pc) | TPIO_C_UNUSED_ONES;
      TPIO_SEL_DIR_A:  rbyte = da;
      TPIO_SEL_DIR_B:  rbyte = db;
      TPIO_SEL_DIR_C:  rbyte = dc;
      TPIO_SEL_NONE:   rbyte = 8'h00;
    endcase
    if (addr_valid && !i_hwrite) begin
      state_next.hrdata = {24'h000000, rbyte};
    end
    // Every transfer completes with no wait state and an OKAY response
    state_next.hreadyout = 1'b1;
    state_next.hresp     = TPIO_HRESP_OKAY;

    // Registered pin drive from the updated latch and direction
    state_next.out_a = A_WIDTH'(drive_out(A_STYLE, da, la));
    state_next.oe_a  = A_WIDTH'(drive_oe(A_STYLE, da, la));
    state_next.out_b = B_WIDTH'(drive_out(B_STYLE, db, lb));
    state_next.oe_b  = B_WIDTH'(drive_oe(B_STYLE, db, lb));
    state_next.out_c = C_WIDTH'(drive_out(C_STYLE, dc, lc));
    state_next.oe_c  = C_WIDTH'(drive_oe(C_STYLE, dc, lc));

    if (!i_reset_n) begin
      // Latches keep whatever they hold
      state_next.dir_a     = A_WIDTH'(TPIO_DIR_RESET);
      state_next.dir_b     = B_WIDTH'(TPIO_DIR_RESET);
      state_next.dir_c     = C_WIDTH'(TPIO_DIR_RESET);
      state_next.wr_pend   = 1'b0;
      state_next.wr_idx    = '0;
      state_next.hreadyout = 1'b1;
      state_next.hrdata    = TPIO_WORD_ZERO;
      state_next.hresp     = TPIO_HRESP_OKAY;
      state_next.out_a     = '0;
      state_next.oe_a      = '0;
      state_next.out_b     = '0;
      state_next.oe_b      = '0;
      state_next.out_c     = '0;
      state_next.oe_c      = '0;
    end
  end

  // One register stage holds all state
  always_ff @(posedge i_clk_sys) begin
    state_reg <= state_next;
  end

  assign o_hreadyout             = state_reg.hreadyout;
  assign o_hresp                 = state_reg.hresp;
  assign o_hrdata                = state_reg.hrdata;
  assign o_first_port_lines_out  = state_reg.out_a;
  assign o_first_port_lines_oe   = state_reg.oe_a;
  assign o_second_port_lines_out = state_reg.out_b;
  assign o_second_port_lines_oe  = state_reg.oe_b;
  assign o_narrow_port_lines_out = state_reg.out_c;
  assign o_narrow_port_lines_oe  = state_reg.oe_c;

endmodule : tpio_top

// >>> logic/tpio_sync_unused_marker.sv
// Holds no logic; the pin synchroniser is kept in tpio_sync.sv

// >>> testbench/tpio_assertions.sv
// Concurrent checks on the ports of the parallel I/O block
`timescale 1ns/1ps
module tpio_assertions
  import tpio_pkg::*;
#(
  parameter int A_WIDTH = 8,
  parameter int B_WIDTH = 8,
  parameter int C_WIDTH = 4
) (
  // Clock and reset
  input wire logic                       i_clk_sys,
  input wire logic                       i_reset_n,
  // Bus
  input wire logic                       i_hsel,
  input wire logic [TPIO_ADDR_WIDTH-1:0] i_haddr,
  input wire logic [1:0]                 i_htrans,
  input wire logic                       i_hwrite,
  input wire logic [31:0]                i_hwdata,
  input wire logic                       i_hready,
  input wire logic                       o_hreadyout,
  input wire logic                       o_hresp,
  input wire logic [31:0]                o_hrdata,
  // Pins
  input wire logic [A_WIDTH-1:0]         o_first_port_lines_out,
  input wire logic [A_WIDTH-1:0]         o_first_port_lines_oe,
  input wire logic [C_WIDTH-1:0]         o_narrow_port_lines_oe,
  input wire logic [B_WIDTH-1:0]         o_second_port_lines_out,
  input wire logic [B_WIDTH-1:0]         o_second_port_lines_oe,
  input wire logic [C_WIDTH-1:0]         o_narrow_port_lines_out
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic taken;
  assign taken = i_hsel && i_hready && (i_htrans == TPIO_HTRANS_NONSEQ);
  // Address phase then data phase of a write
  sequence wr_s(logic [7:0] idx);
    taken && i_hwrite && (i_haddr[9:2] == idx) ##1 1'b1;
  endsequence
  sequence rd_s(logic [7:0] idx);
    taken && !i_hwrite && (i_haddr[9:2] == idx);
  endsequence
  hresp_okay_a: assert property (o_hresp == TPIO_HRESP_OKAY) else $error("hresp not okay");
  ready_high_a: assert property (o_hreadyout) else $error("hreadyout low");
  dir_reset_a: assert property ($rose(i_reset_n) |->
    (o_first_port_lines_oe == '0) && (o_narrow_port_lines_oe == '0)) else $error("oe after reset");
  rdata_upper_a: assert property (o_hrdata[31:8] == 24'h0) else $error("hrdata upper bits");
  narrow_ones_a: assert property (rd_s(TPIO_IDX_DATA_C) |=> o_hrdata[7:4] == 4'hf)
    else $error("narrow data upper bits");
  dir_first_a: assert property (wr_s(TPIO_IDX_DIR_A) |=>
    o_first_port_lines_oe == $past(i_hwdata[A_WIDTH-1:0])) else $error("first port oe");
  dir_narrow_a: assert property (wr_s(TPIO_IDX_DIR_C) |=>
    o_narrow_port_lines_oe == $past(i_hwdata[C_WIDTH-1:0])) else $error("narrow port oe");
  latch_write_a: assert property (wr_s(TPIO_IDX_DATA_A) |=>
    o_first_port_lines_out == ($past(i_hwdata[A_WIDTH-1:0]) & o_first_port_lines_oe))
    else $error("first port latch");
  read_latch_a: assert property (rd_s(TPIO_IDX_DATA_A) |=> ((o_hrdata[A_WIDTH-1:0] ^
    o_first_port_lines_out) & o_first_port_lines_oe) == '0)
    else $error("output pin read source");
  dir_second_a: assert property (wr_s(TPIO_IDX_DIR_B) |=>
    o_second_port_lines_oe == $past(i_hwdata[B_WIDTH-1:0])) else $error("second port oe");
  latch_second_a: assert property (wr_s(TPIO_IDX_DATA_B) |=>
    o_second_port_lines_out == ($past(i_hwdata[B_WIDTH-1:0]) & o_second_port_lines_oe))
    else $error("second port latch");
  latch_narrow_a: assert property (wr_s(TPIO_IDX_DATA_C) |=>
    o_narrow_port_lines_out == ($past(i_hwdata[C_WIDTH-1:0]) & o_narrow_port_lines_oe))
    else $error("narrow port latch");
endmodule : tpio_assertions

bind tpio_top tpio_assertions #(.A_WIDTH(A_WIDTH), .B_WIDTH(B_WIDTH), .C_WIDTH(C_WIDTH)) i_chk (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
  .o_first_port_lines_out(o_first_port_lines_out), .o_first_port_lines_oe(o_first_port_lines_oe),
  .o_narrow_port_lines_oe(o_narrow_port_lines_oe),
  .o_second_port_lines_out(o_second_port_lines_out),
  .o_second_port_lines_oe(o_second_port_lines_oe),
  .o_narrow_port_lines_out(o_narrow_port_lines_out));

// >>> testbench/tpio_ext_pins.sv
// External circuit model on the pins of one port
`timescale 1ns/1ps
module tpio_ext_pins #(
  parameter int W = 8
) (
  // Block pin drive
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  // Far-side load
  input  wire logic         i_fight,
  input  wire logic [W-1:0] i_ext,
  output logic      [W-1:0] o_level
);
  // A fighting load pulls driven pins the other way; released pins follow the load
  assign o_level = (i_oe & (i_fight ? ~i_out : i_out)) | (~i_oe & i_ext);
endmodule : tpio_ext_pins

// >>> testbench/tpio_tb.sv
// Self-checking bench for the parallel I/O block
`timescale 1ns/1ps
module tb;
  import tpio_pkg::*;
  logic        i_clk_sys, i_reset_n, hsel, hwrite, rd_phase, fight;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, seed, w;
  logic        hreadyout, hresp;
  logic [31:0] hrdata;
  logic [7:0]  a_out, a_oe, a_lvl, b_out, b_oe, b_lvl;
  logic [3:0]  c_out, c_oe, c_lvl;
  logic [7:0]  ext [3];
  logic [7:0]  lat [3];
  logic [7:0]  dir [3];
  logic [7:0]  exp_q [$];
  int          miscompares, check_count;
  tpio_top i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_first_port_lines_in(a_lvl), .o_first_port_lines_out(a_out),
    .o_first_port_lines_oe(a_oe), .i_second_port_lines_in(b_lvl),
    .o_second_port_lines_out(b_out), .o_second_port_lines_oe(b_oe),
    .i_narrow_port_lines_in(c_lvl), .o_narrow_port_lines_out(c_out),
    .o_narrow_port_lines_oe(c_oe));
  tpio_ext_pins #(.W(8)) i_pa (.i_out(a_out), .i_oe(a_oe), .i_fight(fight), .i_ext(ext[0]),
    .o_level(a_lvl));
  tpio_ext_pins #(.W(8)) i_pb (.i_out(b_out), .i_oe(b_oe), .i_fight(fight), .i_ext(ext[1]),
    .o_level(b_lvl));
  tpio_ext_pins #(.W(4)) i_pc (.i_out(c_out), .i_oe(c_oe), .i_fight(fight),
    .i_ext(ext[2][3:0]), .o_level(c_lvl));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] adr(logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction : adr
  task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
    @(posedge i_clk_sys);
    hsel <= 1'b1; haddr <= a; htrans <= TPIO_HTRANS_NONSEQ; hwrite <= wr;
    do @(posedge i_clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; rd_phase <= !wr;
    do @(posedge i_clk_sys); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, TPIO_WORD_ZERO);
  endtask : rd
  task automatic close_out();
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge i_clk_sys) begin
    if (rd_phase === 1'b1 && hreadyout === 1'b1) begin
      check_count++;
      if (hrdata !== {24'h0, exp_q[0]}) begin
        miscompares++;
        $display("unexpected hrdata: expected %h seen %h", exp_q[0], hrdata);
      end
      void'(exp_q.pop_front());
    end
  end
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    miscompares++;
    close_out();
  end
  initial begin
    logic [7:0] m;
    i_reset_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; rd_phase = 1'b0;
    hsize = TPIO_HSIZE_WORD; hwdata = '0; fight = 1'b0; seed = 32'h0ab7;
    ext = '{8'h5a, 8'ha5, 8'h3c};
    repeat (12) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    for (int p = 0; p < 3; p++) rd(adr(8'(TPIO_IDX_DIR_A + p)), TPIO_DIR_RESET);
    for (int r = 0; r < 4; r++) begin
      for (int p = 0; p < 3; p++) begin
        m = (p == 2) ? 8'h0f : 8'hff;
        w = rnd();
        lat[p] = w[7:0];
        xfer(adr(8'(TPIO_IDX_DATA_A + p)), 1'b1, w);
        ext[p] <= 8'(rnd());
        fight <= r[0];
        w = (r == 0) ? 32'h0 : rnd();
        dir[p] = w[7:0];
        xfer(adr(8'(TPIO_IDX_DIR_A + p)), 1'b1, w);
        repeat (2) @(posedge i_clk_sys);
        rd(adr(8'(TPIO_IDX_DATA_A + p)), (((dir[p] & lat[p]) | (~dir[p] & ext[p])) & m)
          | ((p == 2) ? TPIO_C_UNUSED_ONES : 8'h00));
        rd(adr(8'(TPIO_IDX_DIR_A + p)), dir[p] & m);
      end
    end
    xfer(32'h0000_0040, 1'b1, rnd());
    rd(32'h0000_0040, 8'h00);
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(adr(TPIO_IDX_DIR_A), TPIO_DIR_RESET);
    xfer(adr(TPIO_IDX_DIR_A), 1'b1, 32'h0000_00ff);
    rd(adr(TPIO_IDX_DATA_A), lat[0]);
    repeat (2) @(posedge i_clk_sys);
    close_out();
  end
endmodule : tb
